/* File: rtl/dte_pkg.sv */
// Purpose: constants and types shared by the DTE interchange controller
// Assumes: positive logic in the core, 1 = ON, 0 = OFF
// Notes: cycle counts derive from the 125 MHz system clock
// Notes on behaviour
// RULE1 - hold transmit data until ready-for-sending ON
// RULE2 - modem drops ready-for-sending to pause us
// RULE3 - check ready-for-sending only between blocks
// RULE4 - ready-for-sending timeout allows several seconds
// RULE5 - watch data-set-ready when using connect control
// RULE6 - dead modem or cable reads OFF
// RULE7 - watch carrier detect for switched far transmitter
// RULE8 - block protocol may ignore carrier detect
// RULE9 - rate select driven from internal logic
// RULE10 - track modem rate indication
// RULE11 - own element clock within 0.01 percent
// RULE12 - own clock half duty, falls mid-element
// RULE13 - own element clock OFF when unused
// RULE14 - modem holds its unused transmit clock OFF
// RULE15 - change data on modem clock rising edge
// RULE16 - transmit and receive clocks phase-independent
// RULE17 - sample received data on falling clock edge
// RULE18 - no backward data before backward ready
// RULE19 - backward line signal held past last bit
// RULE20 - backward line signal on only when detector OFF
// RULE21 - request-to-send held past last data bit
// RULE22 - re-raise request only after ready drops (the code checks this only when hd_mode is set)
// RULE23 - control inputs act on level, not edge
// RULE24 - idle transmit line rests at mark
package dte_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BIT_RATE_HZ = 9600;
  localparam int unsigned BC_RATE_HZ = 75;
  localparam int unsigned BIT_HALF_CYCLES = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int unsigned BC_HALF_CYCLES = CLK_HZ / (2 * BC_RATE_HZ);
  localparam int unsigned RFS_WAIT_MS = 5000;
  localparam longint unsigned RFS_WAIT_CYCLES = longint'(RFS_WAIT_MS) * CLK_HZ / 1000;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic MARK = 1'b1;

  typedef struct packed {
    logic tx_clk;
    logic rfs;
    logic dsr;
    logic carrier;
    logic rate_ind;
    logic bc_ready;
    logic bc_dcd;
  } dce_in_t;

  typedef struct packed {
    logic txd;
    logic rts;
    logic connect;
    logic rate_sel;
    logic clk113;
    logic bc_txd;
    logic bc_on;
  } dte_out_t;

  typedef struct packed {
    logic rfs_fail;
    logic dsr_lost;
    logic carrier;
    logic rate_ind;
    logic rate_change;
  } status_t;

  typedef enum logic [2:0] {TX_IDLE, TX_RAISE, TX_SEND, TX_DRAIN, TX_DROP} tx_state_t;
  typedef enum logic [2:0] {BC_IDLE, BC_WAIT_DCD, BC_WAIT_RDY, BC_SEND, BC_HOLD} bc_state_t;
endpackage

/* File: rtl/dte_interchange.sv */
// Purpose: DTE side control of the modem interchange circuits
// Assumes: pins already converted to logic levels, 1 = ON
// Notes: receive path runs on the modem receive element clock
`timescale 1ns/1ns
`default_nettype none
module dte_interchange #(
  parameter int unsigned BIT_HALF = dte_pkg::BIT_HALF_CYCLES,
  parameter int unsigned BC_HALF = dte_pkg::BC_HALF_CYCLES,
  parameter int unsigned RFS_WAIT = 32'(dte_pkg::RFS_WAIT_CYCLES)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rx_elem_clk,
  input wire logic rxd,
  input wire dte_pkg::dce_in_t dce_in,
  output var dte_pkg::dte_out_t dte_out,
  input wire logic clk_src_dte,
  input wire logic hd_mode,
  input wire logic use_connect,
  input wire logic connect_req,
  input wire logic block_proto,
  input wire logic rate_sel_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] bc_data,
  input wire logic bc_valid,
  output logic bc_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output var dte_pkg::status_t status
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dte_pkg::dce_in_t sync1_reg;
  dte_pkg::dce_in_t sync2_reg;
  logic tx114_prev_reg;
  logic rfs_s, dsr_s, link_ok;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tx114_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= dce_in;
      sync2_reg <= sync1_reg;
      tx114_prev_reg <= sync2_reg.tx_clk;
    end
  end

  // decisions use the settled level, so a missed edge cannot wedge us
  assign rfs_s = sync2_reg.rfs; // [RULE23]
  // an unpowered modem or open cable is biased to 0 and reads OFF
  assign dsr_s = sync2_reg.dsr; // [RULE6]
  assign link_ok = !(use_connect && !dsr_s); // [RULE5]

  // ----------------------------------------------------------------
  // element timing
  // ----------------------------------------------------------------
  logic [31:0] half_reg;
  logic clk113_reg;
  logic tick;

  // integer divide of the crystal clock keeps the rate error tiny
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_reg <= '0;
      clk113_reg <= 1'b0;
    end else if (!clk_src_dte) begin
      half_reg <= '0;
      clk113_reg <= 1'b0; // [RULE13]
    end else if (half_reg == 32'(BIT_HALF - 1)) begin
      half_reg <= '0;
      clk113_reg <= ~clk113_reg; // [RULE11] [RULE12]
    end else begin
      half_reg <= half_reg + 32'h1;
    end
  end

  // data moves as our clock goes ON, so it falls mid-element;
  // with the modem clock the unused one is ignored
  assign tick = clk_src_dte ? (half_reg == 32'(BIT_HALF - 1) && !clk113_reg) // [RULE12]
              : (sync2_reg.tx_clk && !tx114_prev_reg); // [RULE14] [RULE15]

  // ----------------------------------------------------------------
  // main channel transmitter
  // ----------------------------------------------------------------
  dte_pkg::tx_state_t tx_state;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_cnt_reg;
  logic tx_end_reg;
  logic txd_reg, rts_reg;
  logic load_first, load_next;

  assign load_first = tx_state == dte_pkg::TX_RAISE && rfs_s && tx_valid && tick; // [RULE1] [RULE3]
  assign load_next = tx_state == dte_pkg::TX_SEND && tick && tx_cnt_reg == dte_pkg::LAST_BIT
                     && !tx_end_reg && tx_valid && link_ok;
  assign tx_ready = load_first || load_next;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= dte_pkg::TX_IDLE;
      tx_shift_reg <= '0;
      tx_cnt_reg <= '0;
      tx_end_reg <= 1'b0;
      txd_reg <= dte_pkg::MARK;
      rts_reg <= 1'b0;
    end else if (!link_ok) begin
      tx_state <= dte_pkg::TX_IDLE;
      txd_reg <= dte_pkg::MARK;
      rts_reg <= 1'b0;
    end else begin
      case (tx_state)
        dte_pkg::TX_IDLE: begin
          txd_reg <= dte_pkg::MARK; // [RULE24]
          if (tx_valid && !(hd_mode && rfs_s)) begin // [RULE22]
            rts_reg <= 1'b1;
            tx_state <= dte_pkg::TX_RAISE;
          end
        end
        dte_pkg::TX_RAISE: begin
          // modem pause holds us here with the line at mark
          txd_reg <= dte_pkg::MARK; // [RULE2] [RULE24]
          if (load_first) begin
            tx_shift_reg <= {1'b0, tx_data[7:1]};
            txd_reg <= tx_data[0];
            tx_cnt_reg <= '0;
            tx_end_reg <= tx_last;
            tx_state <= dte_pkg::TX_SEND;
          end
        end
        dte_pkg::TX_SEND: begin
          if (tick) begin
            if (tx_cnt_reg != dte_pkg::LAST_BIT) begin
              txd_reg <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_cnt_reg <= tx_cnt_reg + 3'h1;
            end else if (load_next) begin
              // inside a block the ready line is not rechecked
              tx_shift_reg <= {1'b0, tx_data[7:1]}; // [RULE3]
              txd_reg <= tx_data[0];
              tx_cnt_reg <= '0;
              tx_end_reg <= tx_last;
            end else begin
              txd_reg <= dte_pkg::MARK; // [RULE24]
              tx_state <= dte_pkg::TX_DRAIN;
            end
          end
        end
        dte_pkg::TX_DRAIN: begin
          // one more element time before request may fall
          if (tick) begin // [RULE21]
            if (hd_mode) begin
              rts_reg <= 1'b0;
              tx_state <= dte_pkg::TX_DROP;
            end else begin
              tx_state <= dte_pkg::TX_RAISE;
            end
          end
        end
        dte_pkg::TX_DROP: begin
          if (!rfs_s) tx_state <= dte_pkg::TX_IDLE; // [RULE22]
        end
        default: tx_state <= dte_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ready-for-sending timeout
  // ----------------------------------------------------------------
  logic [31:0] wait_reg;
  logic rfs_fail_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= '0;
      rfs_fail_reg <= 1'b0;
    end else if (!dsr_s || rfs_s || tx_state != dte_pkg::TX_RAISE) begin
      wait_reg <= '0;
      rfs_fail_reg <= 1'b0;
    end else if (wait_reg == 32'(RFS_WAIT - 1)) begin
      rfs_fail_reg <= 1'b1; // [RULE4]
    end else begin
      wait_reg <= wait_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // backward channel transmitter
  // ----------------------------------------------------------------
  dte_pkg::bc_state_t bc_state;
  logic [31:0] bc_div_reg;
  logic bc_tick;
  logic [7:0] bc_shift_reg;
  logic [2:0] bc_cnt_reg;
  logic bc_txd_reg, bc_on_reg;
  logic bc_first, bc_next;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) bc_div_reg <= '0;
    else if (bc_tick) bc_div_reg <= '0;
    else bc_div_reg <= bc_div_reg + 32'h1;
  end

  assign bc_tick = bc_div_reg == 32'(2 * BC_HALF - 1);
  assign bc_first = bc_state == dte_pkg::BC_WAIT_RDY && sync2_reg.bc_ready && bc_tick; // [RULE18]
  assign bc_next = bc_state == dte_pkg::BC_SEND && bc_tick && bc_cnt_reg == dte_pkg::LAST_BIT
                   && bc_valid;
  assign bc_ready = (bc_first || bc_next) && bc_valid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_state <= dte_pkg::BC_IDLE;
      bc_shift_reg <= '0;
      bc_cnt_reg <= '0;
      bc_txd_reg <= dte_pkg::MARK;
      bc_on_reg <= 1'b0;
    end else begin
      case (bc_state)
        dte_pkg::BC_IDLE: begin
          if (bc_valid) bc_state <= dte_pkg::BC_WAIT_DCD;
        end
        dte_pkg::BC_WAIT_DCD: begin
          if (!sync2_reg.bc_dcd) begin // [RULE20]
            bc_on_reg <= 1'b1;
            bc_state <= dte_pkg::BC_WAIT_RDY;
          end
        end
        dte_pkg::BC_WAIT_RDY: begin
          if (bc_first) begin
            bc_shift_reg <= {1'b0, bc_data[7:1]};
            bc_txd_reg <= bc_data[0];
            bc_cnt_reg <= '0;
            bc_state <= dte_pkg::BC_SEND;
          end
        end
        dte_pkg::BC_SEND: begin
          if (bc_tick) begin
            if (bc_cnt_reg != dte_pkg::LAST_BIT) begin
              bc_txd_reg <= bc_shift_reg[0];
              bc_shift_reg <= {1'b0, bc_shift_reg[7:1]};
              bc_cnt_reg <= bc_cnt_reg + 3'h1;
            end else if (bc_next) begin
              bc_shift_reg <= {1'b0, bc_data[7:1]};
              bc_txd_reg <= bc_data[0];
              bc_cnt_reg <= '0;
            end else begin
              bc_txd_reg <= dte_pkg::MARK;
              bc_state <= dte_pkg::BC_HOLD;
            end
          end
        end
        dte_pkg::BC_HOLD: begin
          if (bc_tick) begin // [RULE19]
            bc_on_reg <= 1'b0;
            bc_state <= dte_pkg::BC_IDLE;
          end
        end
        default: bc_state <= dte_pkg::BC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver on the modem receive clock
  // ----------------------------------------------------------------
  // own domain, so any phase against the transmit clock is fine
  logic [7:0] rx_shift_reg, rx_hold_reg;
  logic [2:0] rx_cnt_reg;
  logic rx_tog_reg;

  always_ff @(negedge rx_elem_clk or negedge reset_n) begin // [RULE16] [RULE17]
    if (!reset_n) begin
      rx_shift_reg <= '0;
      rx_hold_reg <= '0;
      rx_cnt_reg <= '0;
      rx_tog_reg <= 1'b0;
    end else begin
      rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
      if (rx_cnt_reg == dte_pkg::LAST_BIT) begin
        rx_hold_reg <= {rxd, rx_shift_reg[7:1]};
        rx_tog_reg <= ~rx_tog_reg;
      end
    end
  end

  // the held byte stays put for a whole character after the toggle
  logic tog1_reg, tog2_reg, tog3_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tog1_reg <= 1'b0;
      tog2_reg <= 1'b0;
      tog3_reg <= 1'b0;
      rx_data_reg <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      tog1_reg <= rx_tog_reg;
      tog2_reg <= tog1_reg;
      tog3_reg <= tog2_reg;
      rx_valid_reg <= 1'b0;
      if (tog2_reg != tog3_reg && (sync2_reg.carrier || block_proto)) begin // [RULE7] [RULE8]
        rx_data_reg <= rx_hold_reg;
        rx_valid_reg <= 1'b1;
      end
    end
  end

  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;

  // ----------------------------------------------------------------
  // rate, connect and status
  // ----------------------------------------------------------------
  logic rate_sel_reg, connect_reg;
  dte_pkg::status_t status_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_sel_reg <= 1'b0;
      connect_reg <= 1'b0;
      status_reg <= '0;
    end else begin
      rate_sel_reg <= rate_sel_req; // [RULE9]
      connect_reg <= connect_req;
      status_reg.rfs_fail <= rfs_fail_reg;
      status_reg.dsr_lost <= !link_ok;
      status_reg.carrier <= sync2_reg.carrier;
      status_reg.rate_ind <= sync2_reg.rate_ind; // [RULE10]
      status_reg.rate_change <= sync2_reg.rate_ind != status_reg.rate_ind;
    end
  end

  assign status = status_reg;
  assign dte_out = '{txd: txd_reg, rts: rts_reg, connect: connect_reg, rate_sel: rate_sel_reg,
                     clk113: clk113_reg, bc_txd: bc_txd_reg, bc_on: bc_on_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_send_after_rfs: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    (tx_state == dte_pkg::TX_SEND && $past(tx_state) == dte_pkg::TX_RAISE) |-> $past(rfs_s))
    else $error("data started without ready-for-sending");
  chk_idle_mark: assert property (@(posedge clk) disable iff (!reset_n) // [RULE24]
    (tx_state == dte_pkg::TX_IDLE || tx_state == dte_pkg::TX_DROP) |-> txd_reg)
    else $error("idle transmit line not at mark");
  chk_rts_held: assert property (@(posedge clk) disable iff (!reset_n) // [RULE21]
    (tx_state == dte_pkg::TX_SEND || tx_state == dte_pkg::TX_DRAIN) |-> rts_reg)
    else $error("request dropped during data");
  chk_rts_reraise: assert property (@(posedge clk) disable iff (!reset_n) // [RULE22]
    ($rose(rts_reg) && $past(hd_mode)) |-> !$past(rfs_s))
    else $error("request raised while ready still on");
  chk_own_clock_off: assert property (@(posedge clk) disable iff (!reset_n) // [RULE13]
    !clk_src_dte |=> !clk113_reg)
    else $error("own element clock running while unused");
  chk_bc_ready_first: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
    (bc_state == dte_pkg::BC_SEND && $past(bc_state) == dte_pkg::BC_WAIT_RDY)
      |-> $past(sync2_reg.bc_ready))
    else $error("backward data before backward ready");
  chk_bc_on_held: assert property (@(posedge clk) disable iff (!reset_n) // [RULE19]
    (bc_state == dte_pkg::BC_SEND || bc_state == dte_pkg::BC_HOLD) |-> bc_on_reg)
    else $error("backward line signal dropped early");
  chk_bc_on_rise: assert property (@(posedge clk) disable iff (!reset_n) // [RULE20]
    $rose(bc_on_reg) |-> !$past(sync2_reg.bc_dcd))
    else $error("backward line signal on with detector on");
  chk_rfs_timeout: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    $rose(rfs_fail_reg) |-> $past(wait_reg) == 32'(RFS_WAIT - 1))
    else $error("ready timeout flagged early");
  chk_dsr_abort: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
    (use_connect && !dsr_s) |=> (!rts_reg && tx_state == dte_pkg::TX_IDLE))
    else $error("transmit kept going with data-set-ready OFF");
endmodule
`default_nettype wire

/* File: bench/dce_model.sv */
// Purpose: modem side model facing the DTE interchange block
// Assumes: 1 = ON on every circuit, ctl levels set by the bench
// Notes: element clocks stand still unless enabled or inside a frame
`timescale 1ns/1ns
`default_nettype none
module dce_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire dte_pkg::dte_out_t dte_out,
  input wire dte_pkg::dce_in_t ctl,
  output var dte_pkg::dce_in_t dce_in,
  output logic rx_elem_clk,
  output logic rxd
);
  // --------
  // circuits toward the terminal
  // --------
  logic [3:0] rts_dly;
  logic clk114;
  initial begin
    clk114 = 1'b0;
    rx_elem_clk = 1'b0;
    rxd = 1'b1;
  end
  // ready lags request so a turnaround is visible; ctl.rfs pauses sending
  // no sink here: ready stays OFF while ctl.rfs is low, and the bench reads txd itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rts_dly <= 4'h0;
    end else begin
      rts_dly <= {rts_dly[2:0], dte_out.rts & ctl.rfs};
    end
  end
  // transmit clock clamped OFF when not in use
  always begin
    #96;
    clk114 = ctl.tx_clk ? ~clk114 : 1'b0;
  end
  assign dce_in = {clk114, rts_dly[3], ctl.dsr, ctl.carrier, ctl.rate_ind, ctl.bc_ready,
    ctl.bc_dcd};
  // data moves on the rising edge so the falling edge is mid-element
  task automatic send_byte(input logic [7:0] b);
    #3;
    for (int i = 0; i < 8; i++) begin
      rx_elem_clk = 1'b1;
      rxd = b[i];
      #16;
      rx_elem_clk = 1'b0;
      #16;
    end
    // a released line must not look like a held last bit
    rxd = ~b[7];
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench for the DTE interchange block
// Assumes: the modem model drives every circuit toward the block
// Notes: short counts via parameters; outputs read at falling clk edges, except grab2 reads txd at falling element clock edges
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int BH = 4;
  localparam int CH = 8;
  logic clk;
  logic reset_n;
  logic rx_elem_clk;
  logic rxd;
  dte_pkg::dce_in_t dce_in;
  dte_pkg::dce_in_t ctl = 7'h18;
  dte_pkg::dte_out_t dte_out;
  dte_pkg::status_t status;
  logic clk_src_dte = 1'b1;
  logic hd_mode = 1'b0;
  logic use_connect = 1'b0;
  logic connect_req = 1'b0;
  logic block_proto = 1'b0;
  logic rate_sel_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] bc_data = 8'h00;
  logic bc_valid = 1'b0;
  logic tx_ready, bc_ready, rx_valid, rts_prev;
  logic [7:0] rx_data;
  logic [7:0] txq[$];
  int cyc = 0;
  int take_cyc = 0;
  int bad_count = 0;
  int num_checks = 0;
  wire logic elem = dte_out.clk113 | dce_in.tx_clk;

  dte_interchange #(.BIT_HALF(BH), .BC_HALF(CH), .RFS_WAIT(50)) dut_u (
    .clk(clk), .reset_n(reset_n), .rx_elem_clk(rx_elem_clk), .rxd(rxd),
    .dce_in(dce_in), .dte_out(dte_out), .clk_src_dte(clk_src_dte), .hd_mode(hd_mode),
    .use_connect(use_connect), .connect_req(connect_req), .block_proto(block_proto),
    .rate_sel_req(rate_sel_req), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .bc_data(bc_data), .bc_valid(bc_valid),
    .bc_ready(bc_ready), .rx_data(rx_data), .rx_valid(rx_valid), .status(status));
  dce_model dce_u (.clk(clk), .reset_n(reset_n), .dte_out(dte_out), .ctl(ctl),
    .dce_in(dce_in), .rx_elem_clk(rx_elem_clk), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // byte source: holds valid and data until the taking edge
  always @(posedge clk) begin
    if (tx_ready === 1'b1) begin
      take_cyc = cyc;
      void'(txq.pop_front());
    end
    cyc++;
    tx_valid <= txq.size() != 0;
    tx_last <= txq.size() == 1;
    if (txq.size() != 0) tx_data <= txq[0];
  end
  // request may only come back once ready has gone
  always @(negedge clk) begin
    if (dte_out.rts === 1'b1 && rts_prev === 1'b0) chk("rfs_at_rts", 8'h00, {7'h00, dce_in.rfs});
    rts_prev = dte_out.rts;
  end
  // --------
  // helpers
  // --------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic grab2(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] got;
    got = 16'h0000;
    txq.push_back(a);
    txq.push_back(b);
    for (int k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge elem);
      got = {dte_out.txd, got[15:1]};
    end
    chk("tx_byte0", a, got[7:0]);
    chk("tx_byte1", b, got[15:8]);
  endtask
  task automatic rts_low();
    for (int k = 0; k < 300 && dte_out.rts !== 1'b0; k++) @(negedge clk);
  endtask
  task automatic rx_try(input logic [7:0] b, input logic want);
    logic seen;
    seen = 1'b0;
    dce_u.send_byte(b);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (rx_valid === 1'b1) seen = 1'b1;
      if (rx_valid === 1'b1) chk("rx_data", b, rx_data);
    end
    chk("rx_valid", {7'h00, want}, {7'h00, seen});
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_gate();
    logic seen;
    logic f40;
    seen = 1'b0;
    f40 = 1'b0;
    txq.push_back(8'hA5);
    for (int i = 0; i < 70; i++) begin
      @(negedge clk);
      if (tx_ready === 1'b1 || dte_out.txd !== 1'b1) seen = 1'b1;
      if (i == 40) f40 = status.rfs_fail;
    end
    chk("held_data", 8'h00, {7'h00, seen});
    chk("fail_early", 8'h00, {7'h00, f40});
    chk("fail_late", 8'h01, {7'h00, status.rfs_fail});
    @(posedge clk);
    ctl.rfs <= 1'b1;
    void'(txq.pop_front());
    grab2(8'hA5, 8'h3C);
    chk("fail_clear", 8'h00, {7'h00, status.rfs_fail});
  endtask
  task automatic t_modem();
    @(posedge clk);
    clk_src_dte <= 1'b0;
    ctl.tx_clk <= 1'b1;
    @(negedge clk);
    fork
      grab2(8'hC3, 8'h5A);
      rx_try(8'hB4, 1'b1);
    join
    chk("own_clk_off", 8'h00, {7'h00, dte_out.clk113});
    repeat (40) @(negedge clk);
    chk("idle_mark", 8'h01, {7'h00, dte_out.txd});
  endtask
  task automatic t_half();
    @(posedge clk);
    clk_src_dte <= 1'b1;
    ctl.tx_clk <= 1'b0;
    hd_mode <= 1'b1;
    @(negedge clk);
    grab2(8'h81, 8'h7E);
    rts_low();
    chk("rts_hold", 8'h01, {7'h00, dte_out.rts === 1'b0 && cyc - take_cyc > 2 * BH * 8});
    grab2(8'h12, 8'h34);
    rts_low();
    @(posedge clk);
    hd_mode <= 1'b0;
  endtask
  task automatic t_connect();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    use_connect <= 1'b1;
    connect_req <= 1'b1;
    ctl.dsr <= 1'b0;
    repeat (4) @(negedge clk);
    txq.push_back(8'hF0);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (tx_ready === 1'b1 || dte_out.rts !== 1'b0) seen = 1'b1;
    end
    chk("send_no_dsr", 8'h00, {7'h00, seen});
    chk("dsr_lost", 8'h01, {7'h00, status.dsr_lost});
    chk("connect", 8'h01, {7'h00, dte_out.connect});
    @(posedge clk);
    ctl.dsr <= 1'b1;
    void'(txq.pop_front());
    grab2(8'hF0, 8'h0F);
  endtask
  task automatic t_rate();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    rate_sel_req <= 1'b1;
    ctl.rate_ind <= 1'b1;
    repeat (2) @(negedge clk);
    chk("rate_sel", 8'h01, {7'h00, dte_out.rate_sel});
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (status.rate_change === 1'b1) seen = 1'b1;
    end
    chk("rate_change", 8'h01, {7'h00, seen});
    chk("rate_ind", 8'h01, {7'h00, status.rate_ind});
  endtask
  task automatic t_rx();
    chk("carrier_on", 8'h01, {7'h00, status.carrier});
    rx_try(8'h3C, 1'b1);
    @(posedge clk);
    ctl.carrier <= 1'b0;
    rx_try(8'hD2, 1'b0);
    chk("carrier_off", 8'h00, {7'h00, status.carrier});
    @(posedge clk);
    block_proto <= 1'b1;
    rx_try(8'h69, 1'b1);
  endtask
  task automatic t_back();
    logic seen;
    int t0;
    logic [7:0] got;
    seen = 1'b0;
    got = 8'h00;
    @(posedge clk);
    ctl.bc_dcd <= 1'b1;
    // detector must be through the synchroniser before a byte is offered
    repeat (4) @(posedge clk);
    bc_data <= 8'h6B;
    bc_valid <= 1'b1;
    repeat (40) @(negedge clk);
    chk("bc_on_early", 8'h00, {7'h00, dte_out.bc_on});
    @(posedge clk);
    ctl.bc_dcd <= 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (bc_ready === 1'b1 || dte_out.bc_txd !== 1'b1) seen = 1'b1;
    end
    chk("bc_on", 8'h01, {7'h00, dte_out.bc_on});
    chk("bc_early", 8'h00, {7'h00, seen});
    @(posedge clk);
    ctl.bc_ready <= 1'b1;
    for (int k = 0; k < 200 && bc_ready !== 1'b1; k++) @(negedge clk);
    chk("bc_take", 8'h01, {7'h00, bc_ready});
    t0 = cyc;
    @(posedge clk);
    bc_valid <= 1'b0;
    // sample each backward element near its middle
    for (int i = 0; i < 8; i++) begin
      repeat (i == 0 ? 8 : 16) @(negedge clk);
      got = {dte_out.bc_txd, got[7:1]};
    end
    chk("bc_byte", 8'h6B, got);
    for (int k = 0; k < 400 && dte_out.bc_on !== 1'b0; k++) @(negedge clk);
    chk("bc_hold", 8'h01, {7'h00, dte_out.bc_on === 1'b0 && cyc - t0 > 2 * CH * 8});
  endtask
  // --------
  // run control
  // --------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk("out_reset", 8'h42, {1'b0, dte_out});
    chk("status_reset", 8'h00, {3'h0, status});
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    t_gate();
    t_modem();
    t_half();
    t_connect();
    t_rate();
    t_rx();
    t_back();
    print_verdict();
  end
  // whole run needs a few thousand cycles; this is far beyond that
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
